// ---- logic/adc_port_regs.svh ----
// register offsets, serial word fields, reset values and frame counts
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

// apb byte offsets
`define OFS_CTRL 12'h000
`define OFS_RANGE 12'h004
`define OFS_STATUS 12'h008
`define OFS_SAMPLE_BASE 12'h020
`define OFS_SAMPLE_LAST 12'h03C

// status register fields
`define STAT_ACTIVE_BIT 0
`define STAT_REFINT_BIT 1
`define STAT_COUNT_LO 16

// serial input word fields
`define WORD_WR_BIT 15
`define WORD_SEL_HI 14
`define WORD_SEL_LO 13
`define WORD_CTRL_HI 12
`define WORD_CTRL_LO 6
`define WORD_RANGE_HI 12
`define WORD_RANGE_LO 5
`define SEL_CTRL 2'h0
`define SEL_RANGE_LO 2'h1
`define SEL_RANGE_HI 2'h2

// reset values: external reference, channel 0, single-ended, twos complement
`define CTRL_RST 7'h00
`define RANGE_RST 16'h0000
`define SAMPLE_RST 13'h0000

// frame timing in shift-clock falling edges
`define FRAME_BITS 5'h10
`define TAG_LAST 5'h02
`define SAR_FIRST 5'h03
`define SAR_LAST 5'h0F
`define SCLK_MAX_KHZ 10000

`endif

// ---- logic/adc_port_pkg.sv ----
// types used by the serial control port; its converter core uses none of them
package adc_port_pkg;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_DIFF = 2'h1,
        MODE_PSEUDO4 = 2'h2,
        MODE_PSEUDO7 = 2'h3
    } in_mode_e;

    typedef enum logic [1:0] {
        RNG_PM10 = 2'h0,
        RNG_PM5 = 2'h1,
        RNG_PM2P5 = 2'h2,
        RNG_UNI10 = 2'h3
    } range_e;

    typedef struct packed {
        logic [2:0] chan;
        in_mode_e mode;
        logic coding;
        logic ref_en;
    } ctrl_s;

    typedef enum logic [2:0] {
        ST_TAG = 3'h1,
        ST_SAR = 3'h2,
        ST_DONE = 3'h4
    } frame_e;

    typedef logic signed [12:0] sample_t;

endpackage : adc_port_pkg

// ---- logic/sar_core.sv ----
// successive-approximation register stepped by the falling shift clock
`timescale 1ns/10ps
`default_nettype none

module sar_core #(
    parameter int WIDTH = 13
) (
    input wire logic sclk,
    input wire logic clr,
    input wire logic step,
    input wire logic [WIDTH-1:0] target,
    output logic decide,
    output logic [WIDTH-1:0] result
);

    logic [WIDTH-1:0] acc_r;
    logic [WIDTH-1:0] probe_r;
    logic [WIDTH-1:0] trial;

    assign trial = acc_r | probe_r;
    // one compare per edge, msb first, so each bit is ready to shift out
    assign decide = (target >= trial);
    assign result = acc_r;

    always_ff @(negedge sclk or posedge clr) begin
        if (clr) begin
            acc_r <= '0;
            probe_r <= {1'b1, {(WIDTH-1){1'b0}}};
        end else if (step) begin
            acc_r <= decide ? trial : acc_r;
            probe_r <= probe_r >> 1;
        end
    end

endmodule : sar_core

`default_nettype wire

// ---- logic/adc_serial_control_port.sv ----
// serial control and readout port of an eight-channel converter, apb view
//
// What this block does
// R1 - frame select low bounds each transfer and its fall starts a conversion.
// R2 - serial input bits are captured on each falling shift-clock edge.
// R3 - a three-bit channel field in the control word picks the channel.
// R4 - a two-bit mode field picks single, differential or pseudo inputs.
// R5 - each channel has its own two-bit range held in the range registers.
// R6 - after reset the external reference is used until software enables it.
// R7 - result bits leave on falling edges, sixteen clocks read one result.
// R8 - the word is three tag bits, a sign bit and twelve bits, msb first.
// R9 - the conversion is clocked by the shift clock and nothing else.
// R10 - coding bit one gives straight binary, zero gives twos complement.
// R11 - a conversion takes sixteen shift-clock cycles.
// R12 - the serial output is driven only while the frame is active.
// R13 - the host writes the next control word while reading the result.
`timescale 1ns/10ps
`default_nettype none
`include "adc_port_regs.svh"

module adc_serial_control_port #(
    parameter int CHANNELS = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic reference_pin_oe
);

    function automatic adc_port_pkg::sample_t sat13(
        input logic signed [13:0] d
    );
        if (d > 14'sh0FFF) begin
            return 13'sh0FFF;
        end else if (d < 14'sh3000) begin
            return 13'sh1000;
        end
        return d[12:0];
    endfunction : sat13

    // ---------------- system clock side ----------------
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic [15:0] frame_cnt_r;
    adc_port_pkg::sample_t sample_r [CHANNELS];
    adc_port_pkg::sample_t shadow_r [CHANNELS];
    adc_port_pkg::ctrl_s ctrl_mirror_r;
    logic [15:0] range_mirror_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic ref_oe_r;

    // ---------------- link side ----------------
    adc_port_pkg::ctrl_s ctrl_r;
    logic [15:0] range_r;
    logic [4:0] cnt_r;
    adc_port_pkg::frame_e state_r;
    adc_port_pkg::frame_e state_nxt;
    logic [15:0] shift_r;
    logic dout_r;
    logic oe_r;

    // apb decode
    logic setup;
    logic wr_en;
    logic hit_ctrl;
    logic hit_range;
    logic hit_status;
    logic hit_sample;
    logic mapped;
    logic [2:0] widx;
    logic [31:0] rd_mux;
    logic [31:0] status_w;

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_r & pwrite;
    assign hit_ctrl = (paddr == `OFS_CTRL);
    assign hit_range = (paddr == `OFS_RANGE);
    assign hit_status = (paddr == `OFS_STATUS);
    assign hit_sample = (paddr >= `OFS_SAMPLE_BASE)
                      & (paddr <= `OFS_SAMPLE_LAST)
                      & (paddr[1:0] == 2'h0);
    assign mapped = hit_ctrl | hit_range | hit_status | hit_sample;
    assign widx = paddr[4:2];
    assign status_w = {frame_cnt_r, 14'h0000, ref_oe_r, ~cs_s2_r};
    assign rd_mux = hit_ctrl ? {25'h0000000, ctrl_mirror_r}
                  : hit_range ? {16'h0000, range_mirror_r}
                  : hit_status ? status_w
                  : hit_sample ? {{19{sample_r[widx][12]}}, sample_r[widx]}
                  : 32'h00000000;

    // frame select is a pin: two flops before the clk side looks at it; the link side uses cs_n raw
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end

    // counts frame starts seen, each one a new conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_cnt_r <= 16'h0000;
        end else if (cs_s3_r & ~cs_s2_r) begin
            frame_cnt_r <= frame_cnt_r + 16'h0001; // R1
        end
    end

    // apb answers in the access cycle right after setup, no wait states
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r <= setup ? rd_mux : prdata_r;
        end
    end

    // software sample values stand in for the analog inputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                sample_r[i] <= `SAMPLE_RST;
            end
        end else if (wr_en & hit_sample) begin
            sample_r[widx][7:0] <= pstrb[0] ? pwdata[7:0]
                                            : sample_r[widx][7:0];
            sample_r[widx][12:8] <= pstrb[1] ? pwdata[12:8]
                                             : sample_r[widx][12:8];
        end
    end

    // shadows move only between frames so the link sees frozen words;
    // a write during a frame lands in the next conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                shadow_r[i] <= `SAMPLE_RST;
            end
            ctrl_mirror_r <= adc_port_pkg::ctrl_s'(`CTRL_RST);
            range_mirror_r <= `RANGE_RST;
        end else if (cs_s2_r) begin
            shadow_r <= sample_r;
            ctrl_mirror_r <= ctrl_r;
            range_mirror_r <= range_r;
        end
    end

    // internal reference drives its pin only once enabled over the link
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_oe_r <= 1'b0; // R6
        end else begin
            ref_oe_r <= ctrl_mirror_r.ref_en; // R6
        end
    end

    // ---------------- conversion setup on the link side ----------------
    logic link_clr;
    logic [2:0] tag;
    logic [2:0] pair_lo;
    adc_port_pkg::range_e rng;
    adc_port_pkg::sample_t raw;
    adc_port_pkg::sample_t clipped;
    logic [12:0] target;
    logic sar_bit;
    logic sar_step;
    logic tag_bit;
    logic first_sar;
    logic commit;
    logic [15:0] word;
    logic dout_nxt;
    logic [4:0] cnt_nxt;

    // the frame select clears the frame logic: the clock stops outside frames
    assign link_clr = rst | cs_n; // R1

    assign pair_lo = {ctrl_r.chan[2:1], 1'b0};
    assign tag = (ctrl_r.mode == adc_port_pkg::MODE_DIFF
               || ctrl_r.mode == adc_port_pkg::MODE_PSEUDO4)
               ? pair_lo : ctrl_r.chan; // R3 R4
    assign rng = adc_port_pkg::range_e'(range_r[{tag, 1'b0} +: 2]); // R5
    assign raw = (ctrl_r.mode == adc_port_pkg::MODE_SINGLE)
               ? shadow_r[ctrl_r.chan]
               : (ctrl_r.mode == adc_port_pkg::MODE_PSEUDO7)
               ? sat13(14'(shadow_r[ctrl_r.chan]) - 14'(shadow_r[7]))
               : sat13(14'(shadow_r[pair_lo])
                     - 14'(shadow_r[pair_lo + 3'h1])); // R4
    // unipolar range cannot show a negative input
    assign clipped = (rng == adc_port_pkg::RNG_UNI10 && raw[12])
                   ? 13'sh0000 : raw; // R5
    // search in offset binary so a plain unsigned compare works
    assign target = clipped ^ 13'h1000;

    sar_core #(
        .WIDTH(13)
    ) u_sar (
        .sclk(sclk),
        .clr(link_clr),
        .step(sar_step),
        .target(target),
        .decide(sar_bit),
        .result()
    ); // R9

    // ---------------- frame sequencing on the link side ----------------
    assign sar_step = (state_r == adc_port_pkg::ST_SAR); // R9 R11
    assign first_sar = (cnt_r == `SAR_FIRST);
    assign tag_bit = tag[2'(`TAG_LAST - cnt_r)];
    assign word = {shift_r[14:0], din};
    assign commit = (cnt_r == `SAR_LAST);
    assign cnt_nxt = (cnt_r == `FRAME_BITS) ? cnt_r : cnt_r + 5'h01;

    // tag msb first, then sign, then twelve bits; sign flips for twos
    // complement since offset binary carries it inverted
    always_comb begin
        state_nxt = state_r;
        dout_nxt = 1'b0;
        unique case (state_r)
            adc_port_pkg::ST_TAG: begin
                dout_nxt = tag_bit; // R8
                if (cnt_r == `TAG_LAST) begin
                    state_nxt = adc_port_pkg::ST_SAR;
                end
            end
            adc_port_pkg::ST_SAR: begin
                dout_nxt = sar_bit ^ (first_sar & ~ctrl_r.coding); // R8 R10
                if (cnt_r == `SAR_LAST) begin
                    state_nxt = adc_port_pkg::ST_DONE; // R11
                end
            end
            adc_port_pkg::ST_DONE: begin
                dout_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(negedge sclk or posedge link_clr) begin
        if (link_clr) begin
            cnt_r <= 5'h00;
            state_r <= adc_port_pkg::ST_TAG;
            shift_r <= 16'h0000;
            dout_r <= 1'b0;
            oe_r <= 1'b0; // R12
        end else begin
            cnt_r <= cnt_nxt;
            state_r <= state_nxt;
            shift_r <= word; // R2
            dout_r <= dout_nxt; // R7
            oe_r <= 1'b1; // R12
        end
    end

    // a written word takes effect at the sixteenth edge, for the next frame
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            ctrl_r <= adc_port_pkg::ctrl_s'(`CTRL_RST); // R6
            range_r <= `RANGE_RST;
        end else if (~cs_n & commit & word[`WORD_WR_BIT]) begin
            unique case (word[`WORD_SEL_HI:`WORD_SEL_LO])
                `SEL_CTRL: begin
                    ctrl_r <= adc_port_pkg::ctrl_s'(
                        word[`WORD_CTRL_HI:`WORD_CTRL_LO]); // R3 R4 R10
                end
                `SEL_RANGE_LO: begin
                    range_r[7:0] <= word[`WORD_RANGE_HI:`WORD_RANGE_LO]; // R5
                end
                `SEL_RANGE_HI: begin
                    range_r[15:8] <= word[`WORD_RANGE_HI:`WORD_RANGE_LO]; // R5
                end
                default: begin
                    ctrl_r <= ctrl_r;
                end
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign dout = dout_r;
    assign dout_oe = oe_r;
    assign reference_pin_oe = ref_oe_r;

endmodule : adc_serial_control_port

`default_nettype wire

// ---- tb/adc_port_monitor.sv ----
// assertions on the apb and serial pins of the converter port
`timescale 1ns/10ps
`default_nettype none
module adc_port_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic reference_pin_oe
);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    chk_ready_next: assert property (@(posedge clk) disable iff (rst)
        setup_s |=> access_s) else $error("no ready after setup");
    chk_ready_pulse: assert property (@(posedge clk) disable iff (rst)
        pready |=> !pready) else $error("ready too long");
    chk_ready_idle: assert property (@(posedge clk) disable iff (rst)
        !psel |-> !pready) else $error("ready without select");
    chk_err_zero: assert property (@(posedge clk) disable iff (rst)
        pslverr |-> pready && prdata == 32'h0) else $error("bad error");
    chk_ref_reset: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> !reference_pin_oe) else $error("ref on at reset");
    chk_oe_idle: assert property (@(posedge clk) disable iff (rst)
        cs_n |-> !dout_oe) else $error("driven outside frame");
    chk_dout_idle: assert property (@(posedge clk) disable iff (rst)
        cs_n |-> !dout) else $error("dout high outside frame");
    // every rise in a frame follows at least one fall
    chk_oe_frame: assert property (@(posedge sclk) disable iff (rst)
        !cs_n |-> dout_oe) else $error("not driven in frame");
endmodule : adc_port_monitor
`default_nettype wire

// ---- tb/host_model.sv ----
// serial host that frames, clocks and reads the converter port
`timescale 1ns/10ps
`default_nettype none
module host_model (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // sclk stands high between frames; odd offset keeps it off clk phase
    task automatic frame(input logic [15:0] w, output logic [15:0] rd);
        #1.3 cs_n = 1'b0;
        #10;
        for (int i = 15; i >= 0; i--) begin
            din = w[i];
            #3 sclk = 1'b0;
            #3 sclk = 1'b1;
            rd[i] = dout;
        end
        cs_n = 1'b1;
        din = ~din;
        #20;
    endtask : frame
endmodule : host_model
`default_nettype wire

// ---- tb/adc_serial_control_port_test.sv ----
// randomized bench for the serial control port
`timescale 1ns/10ps
`default_nettype none
module adc_serial_control_port_test;
    logic clk, rst, psel, penable, pwrite, pslverr, pready, e;
    logic sclk, cs_n, din, dout, dout_oe, reference_pin_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [15:0] seed, r;
    logic signed [12:0] smp [8];
    logic [2:0] c;
    logic [1:0] m;
    logic k, f;
    int num_errors = 0;
    int checked = 0;
    adc_serial_control_port i_dut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe), .reference_pin_oe(reference_pin_oe));
    host_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic print_verdict;
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input string n, input logic [31:0] x,
            input logic [31:0] g);
        checked++;
        if (g !== x) begin
            $display("MISMATCH %s exp %h got %h", n, x, g);
            num_errors++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) begin
            num_errors++;
            print_verdict();
        end
    endtask : apb
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step
    function automatic logic [15:0] expect_word(input logic [2:0] ch,
            input logic [1:0] md, input logic cod);
        logic [2:0] t;
        logic signed [13:0] v;
        t = ch;
        v = smp[ch];
        if (md == 2'h1 || md == 2'h2) begin
            t = ch & 3'h6;
            v = smp[t] - smp[t | 3'h1];
        end
        if (md == 2'h3)
            v = smp[ch] - smp[7];
        if (v > 14'sh0FFF)
            v = 14'sh0FFF;
        if (v < -14'sh1000)
            v = -14'sh1000;
        return {t, v[12] ^ cod, v[11:0]};
    endfunction : expect_word
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        seed = 16'hFA5C;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(1'b1, 12'h000, 32'h7F);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h0, q);
        chk("refpin", 32'h0, {31'h0, reference_pin_oe});
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        for (int i = 0; i < 8; i++) begin
            seed = step(seed);
            smp[i] = seed[12:0];
            apb(1'b1, 12'h020 + 12'(4 * i), {19'h0, seed[12:0]});
        end
        apb(1'b0, 12'h024, 32'h0);
        chk("sample", {{19{smp[1][12]}}, smp[1]}, q);
        // unipolar range on channel 0 clips a negative input to zero
        smp[0] = 13'h1F00;
        apb(1'b1, 12'h020, 32'h1F00);
        i_host.frame({1'b1, 2'h1, 8'hC3, 5'h0}, r);
        apb(1'b0, 12'h004, 32'h0);
        chk("range", 32'hC3, q);
        i_host.frame({1'b1, 2'h1, 8'h00, 5'h0}, r);
        chk("clip", 32'h0, {16'h0, r});
        for (int j = 0; j < 12; j++) begin
            seed = step(seed);
            c = seed[2:0];
            m = (j < 4) ? j[1:0] : seed[4:3];
            k = seed[5];
            f = seed[6];
            smp[c] = seed[15:3];
            apb(1'b1, 12'h020 + 12'(c) * 12'h4, {19'h0, seed[15:3]});
            i_host.frame({1'b1, 2'h0, c, m, k, f, 6'h0}, r);
            apb(1'b0, 12'h000, 32'h0);
            chk("ctrl", {25'h0, c, m, k, f}, q);
            chk("refpin", {31'h0, f}, {31'h0, reference_pin_oe});
            i_host.frame(16'h0000, r);
            chk("word", {16'h0, expect_word(c, m, k)}, {16'h0, r});
        end
        // upper range bank, then a word whose select targets nothing
        i_host.frame({1'b1, 2'h2, 8'hFF, 5'h00}, r);
        i_host.frame({1'b1, 2'h3, 13'h1FFF}, r);
        apb(1'b0, 12'h004, 32'h0);
        chk("range_hi", 32'hFF00, q);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl_keep", {25'h0, c, m, k, f}, q);
        // every frame so far started one conversion: 2 + 24 + 2
        apb(1'b0, 12'h008, 32'h0);
        chk("status", {16'h001C, 14'h0000, f, 1'b0}, q);
        print_verdict();
    end
endmodule : adc_serial_control_port_test
bind adc_serial_control_port adc_port_monitor i_mon (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .dout(dout),
    .dout_oe(dout_oe), .reference_pin_oe(reference_pin_oe));
`default_nettype wire
